// >>> tws_master_model.sv
// Bus master model that drives the two wires of the slave under test.
`timescale 1ns/1ps
module tws_master_model (
  input wire logic scl,
  input wire logic sda,
  output logic scl_lo,
  output logic sda_lo
);
  // ----------------------------------------------------------------
  // Wire phases, 400 ns bit period
  // ----------------------------------------------------------------
  initial begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
  end
  // The high phase starts only once the wire rises, so a slave that
  // stretches the clock is waited for, up to a bounded time.
  task automatic rise();
    scl_lo = 1'b0;
    for (int i = 0; i < 400 && scl !== 1'b1; i++) begin
      #50;
    end
  endtask
  task automatic put_bit(input logic b);
    sda_lo = !b;
    #100;
    rise();
    #200;
    scl_lo = 1'b1;
    #100;
  endtask
  task automatic get_bit(output logic b);
    sda_lo = 1'b0;
    #100;
    rise();
    #100;
    b = sda;
    #100;
    scl_lo = 1'b1;
    #100;
  endtask
  // Works from an idle bus and as a repeated start with SCL low.
  task automatic start();
    sda_lo = 1'b0;
    #100;
    rise();
    #100;
    sda_lo = 1'b1;
    #100;
    scl_lo = 1'b1;
    #100;
  endtask
  task automatic stop();
    sda_lo = 1'b1;
    #100;
    rise();
    #100;
    sda_lo = 1'b0;
    #200;
  endtask
  // ----------------------------------------------------------------
  // Whole bytes, most significant bit first, then the ack bit
  // ----------------------------------------------------------------
  task automatic send(input logic [7:0] b, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i]);
    end
    get_bit(a);
    ack = !a;
  endtask
  task automatic recv(input logic ack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      get_bit(b[i]);
    end
    put_bit(!ack);
  endtask
endmodule // tws_master_model

// >>> tws_pkg.sv
// Constants, state enumeration and state record of the two-wire slave.
package tws_pkg;
  // ----------------------------------------------------------------
  // Register offsets and field positions
  // ----------------------------------------------------------------
  localparam logic [1:0] OFS_OWN = 2'h0;
  localparam logic [1:0] OFS_CTRL = 2'h1;
  localparam logic [1:0] OFS_STAT = 2'h2;
  localparam logic [1:0] OFS_DATA = 2'h3;
  localparam int B_IRQ = 7;
  localparam int B_AE = 6;
  localparam int B_STA = 5;
  localparam int B_STO = 4;
  localparam int B_WC = 3;
  localparam int B_EN = 2;
  localparam int B_IE = 0;
  localparam int B_GCE = 0;
  // ----------------------------------------------------------------
  // Status codes, low three bits always zero
  // ----------------------------------------------------------------
  localparam logic [7:0] ST_BERR = 8'h00;
  localparam logic [7:0] ST_START = 8'h08;
  localparam logic [7:0] ST_SLA_W = 8'h60;
  localparam logic [7:0] ST_ARB_W = 8'h68;
  localparam logic [7:0] ST_GCA = 8'h70;
  localparam logic [7:0] ST_ARB_GCA = 8'h78;
  localparam logic [7:0] ST_RX_ACK = 8'h80;
  localparam logic [7:0] ST_RX_NACK = 8'h88;
  localparam logic [7:0] ST_GC_ACK = 8'h90;
  localparam logic [7:0] ST_GC_NACK = 8'h98;
  localparam logic [7:0] ST_STOP_RX = 8'hA0;
  localparam logic [7:0] ST_SLA_R = 8'hA8;
  localparam logic [7:0] ST_ARB_R = 8'hB0;
  localparam logic [7:0] ST_TX_ACK = 8'hB8;
  localparam logic [7:0] ST_TX_NACK = 8'hC0;
  localparam logic [7:0] ST_LAST_ACK = 8'hC8;
  localparam logic [7:0] ST_NONE = 8'hF8;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 50;
  localparam int START_HOLD_NS = 4000;
  localparam logic [7:0] START_HOLD_CYC =
    8'((START_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] BITS_BYTE = 4'h8;
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_AACK, S_RX, S_RACK, S_TX, S_TACK,
    S_IGN, S_EXIT, S_BERR, S_SGEN, S_MHOLD
  } tws_state_t;
  typedef struct packed {
    tws_state_t st;
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_d;
    logic sda_d;
    logic busy, arb, gc, rw, ack, last, ld;
    logic [7:0] own, data, sh, stat, cnt, rdata;
    logic [1:0] presc;
    logic irq, ae, sta, sto, wc, en, ie;
    logic [3:0] bits;
    logic scl_oe, sda_oe, wake, pin_lo;
  } tws_q_t;
  localparam tws_q_t Q_RST = '0;
endpackage

// >>> tws_slave.sv
// Two-wire slave receiver and transmitter with register port.
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
// Behaviour
// - General-call data acked: 0x90, ack per enable
// - General-call data nacked: 0x98, then unaddressed
// - Stop or restart while addressed as receiver: 0xA0
// - Exit with ack off ignores all addresses
// - Exit with ack on: own, gated general call
// - Pending start request issued when bus free
// - Own address upper bits, LSB enables general call
// - Read bit selects transmit, write selects receive
// - Address match sets flag and valid status
// - Lost arbitration then own read: 0xB0
// - Ack off sends last byte, 0xC0/0xC8
// - After last byte release SDA, ignore master
// - Ack off isolates, monitoring continues
// - Sleep still recognises address with ack on
// - Sleep match wakes, holds SCL till clear
// - Data register not updated while asleep
// - Own read address acked: 0xA8, load data
// - Byte acked by master: 0xB8, send next
// - Misplaced start or stop: bus error 0x00
module tws_slave (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic sleep_mode,
  output logic wake
);
  import tws_pkg::*;

  tws_q_t q;
  tws_q_t d;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic set_irq;
  logic [7:0] code;
  logic own_hit;
  logic gc_hit;

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  function automatic logic [7:0] rd_val(input tws_q_t s,
                                        input logic [1:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      OFS_OWN: v = s.own;
      OFS_CTRL: v = {s.irq, s.ae, s.sta, s.sto, s.wc, s.en, 1'b0, s.ie};
      OFS_STAT: v = {(s.irq ? s.stat[7:3] : ST_NONE[7:3]), 1'b0, s.presc};
      OFS_DATA: v = s.data;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // The first synchroniser stage feeds only the second.
  assign scl = q.scl_s[1];
  assign sda = q.sda_s[1];
  assign scl_rise = scl & ~q.scl_d;
  assign scl_fall = ~scl & q.scl_d;
  assign bus_start = scl & q.scl_d & q.sda_d & ~sda;
  assign bus_stop = scl & q.scl_d & ~q.sda_d & sda;
  assign own_hit = q.ae && (q.sh[7:1] == q.own[7:1]);
  assign gc_hit = q.ae && q.own[B_GCE] && (q.sh == 8'h00);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    set_irq = 1'b0;
    code = q.stat;
    d.scl_s = {q.scl_s[0], scl_in};
    d.sda_s = {q.sda_s[0], sda_in};
    d.scl_d = scl;
    d.sda_d = sda;
    d.wake = 1'b0;
    d.pin_lo = 1'b0;
    d.rdata = 8'h00;
    if (bus_start) begin
      d.busy = 1'b1;
    end
    if (bus_stop) begin
      d.busy = 1'b0;
    end
    if (reg_rd) begin
      d.rdata = rd_val(q, reg_addr);
    end
    if (reg_wr) begin
      case (reg_addr)
        OFS_OWN: d.own = reg_wdata;
        OFS_CTRL: begin
          d.ae = reg_wdata[B_AE];
          d.sta = reg_wdata[B_STA];
          d.sto = reg_wdata[B_STO];
          d.en = reg_wdata[B_EN];
          d.ie = reg_wdata[B_IE];
          if (reg_wdata[B_IRQ]) begin
            d.irq = 1'b0;
          end
        end
        OFS_STAT: d.presc = reg_wdata[1:0];
        OFS_DATA: begin
          // Loading data behind a running transfer would corrupt it.
          if (q.irq) begin
            d.data = reg_wdata;
            d.wc = 1'b0;
          end else begin
            d.wc = 1'b1;
          end
        end
        default: d.wc = q.wc;
      endcase
    end
    case (q.st)
      S_IDLE: begin
        if (bus_start) begin
          d.arb = q.sta;
          d.st = S_ADDR;
          d.bits = 4'h0;
        end else if (q.sta && !q.busy && !q.irq) begin
          d.st = S_SGEN;
          d.cnt = 8'h00;
          d.sda_oe = 1'b1;
          d.sta = 1'b0;
        end
      end
      S_IGN: begin
        if (bus_start) begin
          d.arb = q.sta;
          d.st = S_ADDR;
          d.bits = 4'h0;
        end else if (bus_stop) begin
          // Back to idle so a pending start request can go out.
          d.st = S_IDLE;
        end
      end
      S_ADDR: begin
        if (scl_rise) begin
          d.sh = {q.sh[6:0], sda};
          d.bits = q.bits + 4'h1;
        end else if (scl_fall && q.bits == BITS_BYTE) begin
          if (own_hit || gc_hit) begin
            d.sda_oe = 1'b1;
            d.gc = gc_hit;
            d.rw = q.sh[0];
            d.st = S_AACK;
            d.wake = sleep_mode;
          end else begin
            d.st = S_IGN;
          end
        end
      end
      S_AACK: begin
        if (scl_fall) begin
          d.sda_oe = 1'b0;
          set_irq = 1'b1;
          d.bits = 4'h0;
          d.ld = 1'b1;
          d.arb = 1'b0;
          if (q.rw) begin
            d.st = S_TX;
            code = q.arb ? ST_ARB_R : ST_SLA_R;
          end else begin
            d.st = S_RX;
            if (q.gc) begin
              code = q.arb ? ST_ARB_GCA : ST_GCA;
            end else begin
              code = q.arb ? ST_ARB_W : ST_SLA_W;
            end
          end
        end
      end
      S_RX: begin
        if (scl_rise) begin
          d.sh = {q.sh[6:0], sda};
          d.bits = q.bits + 4'h1;
        end else if (scl_fall && q.bits == BITS_BYTE) begin
          d.ack = q.ae;
          d.sda_oe = q.ae;
          d.st = S_RACK;
        end
      end
      S_RACK: begin
        if (scl_fall) begin
          d.sda_oe = 1'b0;
          // The sleeping clock tree cannot capture the byte.
          if (!sleep_mode) begin
            d.data = q.sh;
          end
          set_irq = 1'b1;
          d.bits = 4'h0;
          if (q.gc) begin
            code = q.ack ? ST_GC_ACK : ST_GC_NACK;
          end else begin
            code = q.ack ? ST_RX_ACK : ST_RX_NACK;
          end
          d.st = q.ack ? S_RX : S_EXIT;
        end
      end
      S_TX: begin
        if (q.ld) begin
          if (!q.irq) begin
            d.sh = q.data;
            d.last = ~q.ae;
            d.ld = 1'b0;
            d.sda_oe = ~q.data[7];
          end
        end else if (scl_fall) begin
          if (q.bits == BITS_BYTE - 4'h1) begin
            d.sda_oe = 1'b0;
            d.st = S_TACK;
          end else begin
            d.sh = {q.sh[6:0], 1'b0};
            d.sda_oe = ~q.sh[6];
            d.bits = q.bits + 4'h1;
          end
        end
      end
      S_TACK: begin
        if (scl_rise) begin
          d.ack = ~sda;
        end else if (scl_fall) begin
          set_irq = 1'b1;
          d.bits = 4'h0;
          if (q.ack && !q.last) begin
            code = ST_TX_ACK;
            d.st = S_TX;
            d.ld = 1'b1;
          end else begin
            code = (q.ack && q.last) ? ST_LAST_ACK : ST_TX_NACK;
            d.st = S_EXIT;
          end
        end
      end
      S_EXIT: begin
        if (!q.irq) begin
          d.st = S_IDLE;
        end
      end
      S_BERR, S_MHOLD: begin
        if (!q.irq && q.sto) begin
          d.st = S_IDLE;
          d.sto = 1'b0;
          d.sda_oe = 1'b0;
        end
      end
      S_SGEN: begin
        d.cnt = q.cnt + 8'h01;
        if (q.cnt == START_HOLD_CYC - 8'h01) begin
          set_irq = 1'b1;
          code = ST_START;
          d.st = S_MHOLD;
        end
      end
      default: d.st = S_IDLE;
    endcase
    // Frame conditions seen while taking part in a transfer.
    if ((bus_start || bus_stop) && (q.st == S_ADDR || q.st == S_AACK ||
        q.st == S_RX || q.st == S_RACK || q.st == S_TX ||
        q.st == S_TACK)) begin
      d.sda_oe = 1'b0;
      // A stop or restart always follows one SCL rise, so one counted
      // bit is still a frame boundary in the receiving states.
      if ((q.st == S_TX ? q.bits != 4'h0 : q.bits > 4'h1) ||
          q.st == S_AACK || q.st == S_RACK || q.st == S_TACK) begin
        set_irq = 1'b1;
        code = ST_BERR;
        d.st = S_BERR;
      end else if (q.st == S_RX) begin
        set_irq = 1'b1;
        code = ST_STOP_RX;
        d.st = S_EXIT;
      end else begin
        d.st = bus_start ? S_ADDR : S_IDLE;
        d.bits = 4'h0;
      end
    end
    // Hardware setting the flag wins over a clearing write.
    if (set_irq) begin
      d.irq = 1'b1;
      d.stat = code;
    end
    // Clock stretching ends only when software clears the flag or the enable bit.
    d.scl_oe = (d.irq && d.busy && (d.st == S_RX || d.st == S_TX ||
               d.st == S_EXIT)) || d.st == S_MHOLD;
    if (!q.en) begin
      d.st = S_IDLE;
      d.sda_oe = 1'b0;
      d.scl_oe = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      q <= Q_RST;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign scl_out = q.pin_lo;
  assign scl_oe = q.scl_oe;
  assign sda_out = q.pin_lo;
  assign sda_oe = q.sda_oe;
  assign wake = q.wake;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_gc_ack_code: assert property (
    q.en && q.st == S_RACK && scl_fall && q.gc && q.ack
    |=> q.irq && q.stat == ST_GC_ACK && q.st == S_RX)
    else $error("general call ack status wrong");
  a_gc_nack_exit: assert property (
    q.en && q.st == S_RACK && scl_fall && q.gc && !q.ack
    |=> q.stat == ST_GC_NACK && q.st == S_EXIT)
    else $error("general call nack exit wrong");
  a_stop_rx_code: assert property (
    q.en && q.st == S_RX && q.bits <= 4'h1 && bus_stop
    |=> q.irq && q.stat == ST_STOP_RX ##1 q.st != S_RX)
    else $error("stop while addressed not reported");
  a_ack_off_ignore: assert property (
    q.en && q.st == S_ADDR && q.bits == BITS_BYTE && scl_fall && !q.ae
    |=> q.st == S_IGN && !q.sda_oe)
    else $error("address answered with ack off");
  a_gca_gate: assert property (
    q.en && q.st == S_ADDR && q.bits == BITS_BYTE && scl_fall &&
    q.sh == 8'h00 && !q.own[B_GCE] && q.own[7:1] != 7'h00
    |=> q.st == S_IGN)
    else $error("general call taken while disabled");
  a_dir_select: assert property (
    q.en && q.st == S_AACK && scl_fall
    |=> q.irq && q.st == ($past(q.rw) ? S_TX : S_RX))
    else $error("direction selection wrong");
  a_last_byte: assert property (
    q.en && q.st == S_TACK && scl_fall && q.last
    |=> q.st == S_EXIT && !q.sda_oe &&
        (q.stat == ST_LAST_ACK || q.stat == ST_TX_NACK))
    else $error("last byte handling wrong");
  a_stretch_hold: assert property (
    q.en && q.busy && q.st == S_RX && q.irq [*3] |-> q.scl_oe)
    else $error("clock not stretched while flag set");
  a_bus_error: assert property (
    q.en && q.st == S_RX && q.bits > 4'h1 && (bus_start || bus_stop)
    |=> q.st == S_BERR && q.irq && q.stat == ST_BERR)
    else $error("bus error not reported");
  a_sleep_wake: assert property (
    q.en && sleep_mode && q.st == S_ADDR && q.bits == BITS_BYTE &&
    scl_fall && own_hit |=> wake && q.sda_oe ##1 !wake)
    else $error("sleep address match did not wake");
  a_start_issue: assert property (
    q.en && q.st == S_IDLE && q.sta && !q.busy && !q.irq && !bus_start
    |=> q.sda_oe && q.st == S_SGEN)
    else $error("pending start not issued");
endmodule // tws_slave

// >>> tws_slave_tb_top.sv
// Self-checking bench for the two-wire slave with a bus master model.
`timescale 1ns/1ps
module tws_slave_tb_top;
  import tws_pkg::*;
  logic ref_clk, reset, reg_wr, reg_rd, sleep_mode, ack;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v, d0;
  logic scl_out, scl_oe, sda_out, sda_oe, wake, m_scl_lo, m_sda_lo;
  logic scl, sda;
  logic [6:0] own;
  int errors, n_compared, cycles, n_wake, k;
  // Open-drain wires with pull-ups: released lines read high.
  assign scl = !((scl_oe && !scl_out) || m_scl_lo);
  assign sda = !((sda_oe && !sda_out) || m_sda_lo);
  tws_slave dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .scl_in(scl), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .sleep_mode(sleep_mode), .wake(wake));
  tws_master_model m (.scl(scl), .sda(sda), .scl_lo(m_scl_lo),
    .sda_lo(m_sda_lo));
  // ----------------------------------------------------------------
  // Clock, timeout and tasks
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // The wake pulse is counted away from the edge that launches it.
  always @(negedge ref_clk) begin
    if (wake === 1'b1) n_wake++;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // Polls for the flag with a bound, then compares the masked code.
  task automatic exp_st(input logic [7:0] e);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 100 && c[B_IRQ] !== 1'b1; i++) rd(OFS_CTRL, c);
    rd(OFS_STAT, c);
    chk(c & 8'hF8, e);
  endtask
  task automatic addr(input logic [7:0] b, input logic e);
    logic a;
    m.start();
    m.send(b, a);
    chk({7'h0, a}, {7'h0, e});
  endtask
  task automatic final_report();
    if (errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    sleep_mode = 1'b0;
    errors = 0;
    n_compared = 0;
    cycles = 0;
    n_wake = 0;
    k = $urandom(95);
    own = 7'($urandom_range(127, 1));
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    rd(OFS_STAT, v);
    chk(v, ST_NONE);
    wr(OFS_OWN, {own, 1'b1});
    wr(OFS_STAT, 8'($urandom_range(3, 0)));
    wr(OFS_CTRL, 8'h44);
    wr(OFS_DATA, 8'h5A);
    rd(OFS_CTRL, v);
    chk(v, 8'h4C);
    for (k = 0; k < 2; k++) begin
      wr(OFS_CTRL, 8'h44);
      addr({own, 1'b1}, 1'b1);
      exp_st(ST_SLA_R);
      chk({7'h0, scl_oe}, 8'h01);
      d0 = 8'($urandom);
      wr(OFS_DATA, d0);
      wr(OFS_CTRL, 8'hC4);
      m.recv(1'b1, v);
      chk(v, d0);
      exp_st(ST_TX_ACK);
      wr(OFS_DATA, ~d0);
      wr(OFS_CTRL, 8'h84);
      m.recv(k[0], v);
      chk(v, ~d0);
      exp_st(k == 1 ? ST_LAST_ACK : ST_TX_NACK);
      wr(OFS_CTRL, 8'hC4);
      m.recv(1'b0, v);
      chk(v, 8'hFF);
      m.stop();
    end
    addr(8'h00, 1'b1);
    exp_st(ST_GCA);
    wr(OFS_CTRL, 8'hC4);
    d0 = 8'($urandom);
    m.send(d0, ack);
    exp_st(ST_GC_ACK);
    rd(OFS_DATA, v);
    chk(v, d0);
    wr(OFS_CTRL, 8'h84);
    m.send(~d0, ack);
    chk({7'h0, ack}, 8'h00);
    exp_st(ST_GC_NACK);
    wr(OFS_CTRL, 8'hC4);
    m.send(d0, ack);
    chk({7'h0, ack}, 8'h00);
    m.stop();
    wr(OFS_OWN, {own, 1'b0});
    addr(8'h00, 1'b0);
    m.stop();
    wr(OFS_CTRL, 8'h04);
    addr({own, 1'b0}, 1'b0);
    m.stop();
    rd(OFS_STAT, v);
    chk(v & 8'hF8, ST_NONE);
    wr(OFS_CTRL, 8'h44);
    addr({own, 1'b0}, 1'b1);
    exp_st(ST_SLA_W);
    wr(OFS_CTRL, 8'hC4);
    m.send(d0, ack);
    exp_st(ST_RX_ACK);
    wr(OFS_CTRL, 8'hC4);
    m.stop();
    exp_st(ST_STOP_RX);
    wr(OFS_CTRL, 8'hC4);
    @(posedge ref_clk);
    sleep_mode <= 1'b1;
    k = n_wake;
    addr({own, 1'b0}, 1'b1);
    exp_st(ST_SLA_W);
    chk(8'(n_wake - k), 8'h01);
    chk({7'h0, scl_oe}, 8'h01);
    wr(OFS_CTRL, 8'hC4);
    repeat (2) @(posedge ref_clk);
    #1;
    chk({7'h0, scl_oe}, 8'h00);
    // A byte taken while asleep leaves the data register alone.
    m.send(~d0, ack);
    exp_st(ST_RX_ACK);
    rd(OFS_DATA, v);
    chk(v, d0);
    wr(OFS_CTRL, 8'hC4);
    sleep_mode <= 1'b0;
    repeat (3) m.put_bit(1'b0);
    m.stop();
    exp_st(ST_BERR);
    wr(OFS_CTRL, 8'hD4);
    rd(OFS_CTRL, v);
    chk(v, 8'h44);
    chk({6'h0, scl_oe, sda_oe}, 8'h00);
    // A foreign transfer holds the start request back until a restart
    // addresses us, which counts as lost arbitration.
    addr({own ^ 7'h01, 1'b1}, 1'b0);
    wr(OFS_CTRL, 8'h64);
    addr({own, 1'b1}, 1'b1);
    exp_st(ST_ARB_R);
    wr(OFS_DATA, d0);
    wr(OFS_CTRL, 8'h84);
    m.recv(1'b0, v);
    chk(v, d0);
    exp_st(ST_TX_NACK);
    wr(OFS_CTRL, 8'hC4);
    m.stop();
    wr(OFS_CTRL, 8'h64);
    exp_st(ST_START);
    wr(OFS_CTRL, 8'hD4);
    final_report();
  end
endmodule // tws_slave_tb_top
